/* File: src/priority_interrupt_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller
   import prio_irq_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire logic [NUM_EXT-1:0]    external_request,
   input  wire logic [NUM_PERIPH-1:0] periph_event,
   input  wire logic                  aux_pll_trap,
   input  wire logic                  loop_stack_trap,
   input  wire logic                  soft_hard_trap,
   input  wire logic                  trap_level_msb,
   output logic                       irq_request,
   output logic [7:0]                 vector_number,
   output logic [3:0]                 pending_level,
   output logic                       variable_latency,
   output logic                       alternate_vector_table_enable,
   output logic                       irq_out
);

   // field of one source inside the packed priority word
   function automatic logic [2:0] prio_of(input logic [NUM_SRC*3-1:0] p, input int idx);
      prio_of = p[idx*3 +: 3];
   endfunction

   // true for an aligned word inside the priority block
   function automatic logic is_prio_addr(input logic [7:0] a);
      is_prio_addr = a >= ADDR_IRQ_PRIO0 && a < ADDR_PENDING_VEC && a[1:0] == 2'h0;
   endfunction

   // first source index held by the priority word at address a
   function automatic int prio_base(input logic [7:0] a);
      prio_base = int'(a[5:2] - ADDR_IRQ_PRIO0[5:2]) * SRC_PER_PRIO_REG;
   endfunction

   logic [NUM_SRC-1:0]   irq_flag_regs_ff;
   logic [NUM_SRC-1:0]   irq_enable_regs_ff;
   logic [NUM_SRC*3-1:0] irq_priority_regs_ff;
   logic [15:0]          global_ctrl_one_ff;
   logic [15:0]          global_ctrl_two_ff;
   logic [15:0]          global_ctrl_three_ff;
   logic [15:0]          global_ctrl_four_ff;
   logic [2:0]           priority_level_bits_ff;
   logic                 priority_level_msb_ff;
   logic                 variable_latency_ff;
   logic [NUM_EXT-1:0]   ext_prev_ff;
   logic [NUM_EVT-1:0]   evt_status_ff;
   logic [NUM_EVT-1:0]   evt_mask_ff;
   logic                 irq_request_ff;
   logic [7:0]           vector_number_ff;
   logic [3:0]           pending_level_ff;
   logic                 pready_ff;
   logic [31:0]          prdata_ff;
   logic                 pslverr_ff;
   logic                 irq_out_ff;

   logic                 wr_en;
   logic                 setup;
   logic [15:0]          wdata;
   logic [NUM_EXT-1:0]   ext_edge;
   logic [NUM_SRC-1:0]   src_set;
   logic [3:0]           cpu_level;
   logic                 user_blocked;
   logic                 nxt_found;
   logic [7:0]           nxt_vector;
   logic [3:0]           nxt_level;
   logic [31:0]          nxt_prdata;
   logic                 nxt_slverr;
   logic [15:0]          trap_set3;
   logic [15:0]          trap_set4;
   logic [NUM_EVT-1:0]   evt_set;

   // write happens at the access edge only; the slave answers in the first access cycle
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pready_ff;
   assign wdata = pwdata[15:0];

   // apb handshake: one wait-free access, ready registered from the setup cycle
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end
      else
      begin
         pready_ff <= setup;
         pslverr_ff <= setup & nxt_slverr;
         if (setup && !pwrite)
            prdata_ff <= nxt_prdata;
         else if (!setup)
            prdata_ff <= 32'h00000000;
      end
   end

   // read mux; unmapped addresses read zero and raise pslverr
   always_comb
   begin
      nxt_prdata = 32'h00000000;
      nxt_slverr = 1'b0;
      // unaligned priority addresses fall through to the error default
      if (is_prio_addr(paddr))
      begin
         for (int i = 0; i < SRC_PER_PRIO_REG; i++)
            nxt_prdata[i*PRIO_FIELD_STRIDE +: 3] = prio_of(irq_priority_regs_ff,
               prio_base(paddr) + i);
      end
      else
      begin
         unique case (paddr)
            ADDR_GCTRL_ONE:   nxt_prdata[15:0] = global_ctrl_one_ff;
            ADDR_GCTRL_TWO:   nxt_prdata[15:0] = global_ctrl_two_ff;
            ADDR_GCTRL_THREE: nxt_prdata[15:0] = global_ctrl_three_ff;
            ADDR_GCTRL_FOUR:  nxt_prdata[15:0] = global_ctrl_four_ff;
            ADDR_IRQ_FLAG:    nxt_prdata[NUM_SRC-1:0] = irq_flag_regs_ff;
            ADDR_IRQ_ENABLE:  nxt_prdata[NUM_SRC-1:0] = irq_enable_regs_ff;
            ADDR_PENDING_VEC: nxt_prdata[11:0] = {pending_level_ff, vector_number_ff};
            ADDR_CPU_STATUS:  nxt_prdata[SR_LEVEL_LSB +: 3] = priority_level_bits_ff;
            ADDR_CORE_CTRL:
            begin
               nxt_prdata[CC_VARIABLE_LATENCY] = variable_latency_ff;
               nxt_prdata[CC_LEVEL_MSB] = priority_level_msb_ff;
            end
            ADDR_EVT_STATUS:  nxt_prdata[NUM_EVT-1:0] = evt_status_ff;
            ADDR_EVT_MASK:    nxt_prdata[NUM_EVT-1:0] = evt_mask_ff;
            default:          nxt_slverr = 1'b1;
         endcase
      end
   end

   // external requests: gc2 low bits pick the active edge, 1 = falling
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ext_prev_ff <= '0;
      else
         ext_prev_ff <= external_request;
   end

   // select bits reset to rising, so idle-low pins give no false edge after reset
   assign ext_edge = (external_request & ~ext_prev_ff & ~global_ctrl_two_ff[NUM_EXT-1:0])
                   | (~external_request & ext_prev_ff & global_ctrl_two_ff[NUM_EXT-1:0]);
   assign src_set = {periph_event, ext_edge};

   // request flags: a set in the same cycle as a software clear wins
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_flag_regs_ff <= '0;
      else if (wr_en && paddr == ADDR_IRQ_FLAG)
         irq_flag_regs_ff <= (irq_flag_regs_ff & wdata[NUM_SRC-1:0]) | src_set;
      else
         irq_flag_regs_ff <= irq_flag_regs_ff | src_set;
   end

   // enable bits, one per source in vector order
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_enable_regs_ff <= '0;
      else if (wr_en && paddr == ADDR_IRQ_ENABLE)
         irq_enable_regs_ff <= wdata[NUM_SRC-1:0];
   end

   // priority fields, four per word, bit 3 of each nibble unused
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_priority_regs_ff <= '0;
      else if (wr_en && is_prio_addr(paddr))
      begin
         for (int i = 0; i < SRC_PER_PRIO_REG; i++)
            irq_priority_regs_ff[(prio_base(paddr) + i) * 3 +: 3]
               <= wdata[i*PRIO_FIELD_STRIDE +: 3];
      end
   end

   // global controls one and two, plain software storage
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         global_ctrl_one_ff <= 16'h0000;
         global_ctrl_two_ff <= GC2_RESET;
      end
      else if (wr_en)
      begin
         if (paddr == ADDR_GCTRL_ONE)
            global_ctrl_one_ff <= wdata & GC1_WRITE_MASK;
         if (paddr == ADDR_GCTRL_TWO)
            global_ctrl_two_ff <= wdata & GC2_WRITE_MASK;
      end
   end

   // trap flags are sticky; software clears with a one, a new trap wins
   always_comb
   begin
      trap_set3 = 16'h0000;
      trap_set4 = 16'h0000;
      trap_set3[GC3_AUX_PLL_FLAG] = aux_pll_trap;
      trap_set3[GC3_LOOP_STACK_FLAG] = loop_stack_trap;
      trap_set4[GC4_SOFT_HARD_TRAP] = soft_hard_trap;
   end

   // trap flag words three and four
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         global_ctrl_three_ff <= 16'h0000;
         global_ctrl_four_ff <= 16'h0000;
      end
      else
      begin
         if (wr_en && paddr == ADDR_GCTRL_THREE)
            global_ctrl_three_ff <= (global_ctrl_three_ff & ~wdata) | trap_set3;
         else
            global_ctrl_three_ff <= global_ctrl_three_ff | trap_set3;
         if (wr_en && paddr == ADDR_GCTRL_FOUR)
            global_ctrl_four_ff <= (global_ctrl_four_ff & ~wdata) | trap_set4;
         else
            global_ctrl_four_ff <= global_ctrl_four_ff | trap_set4;
      end
   end

   // status level bits; frozen while nesting is disabled
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         priority_level_bits_ff <= 3'h0;
      else if (wr_en && paddr == ADDR_CPU_STATUS && !global_ctrl_one_ff[GC1_NESTING_DISABLE])
         priority_level_bits_ff <= wdata[SR_LEVEL_LSB +: 3];
   end

   // top level bit follows the core only; bus writes never reach it
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         priority_level_msb_ff <= 1'b0;
      else
         priority_level_msb_ff <= trap_level_msb;
   end

   // latency select
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         variable_latency_ff <= 1'b0;
      else if (wr_en && paddr == ADDR_CORE_CTRL)
         variable_latency_ff <= wdata[CC_VARIABLE_LATENCY];
   end

   // cpu level and the block-all condition
   assign cpu_level = {priority_level_msb_ff, priority_level_bits_ff};
   assign user_blocked = priority_level_msb_ff
                       || priority_level_bits_ff == LEVEL_BLOCK_ALL;

   // arbitration: scan downward so a tie keeps the lower vector
   // a zero priority field never beats level 0, so it parks its source
   always_comb
   begin
      nxt_found = 1'b0;
      nxt_vector = 8'h00;
      nxt_level = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         if (irq_flag_regs_ff[i] && irq_enable_regs_ff[i]
             && {1'b0, prio_of(irq_priority_regs_ff, i)} > cpu_level
             && (!nxt_found || {1'b0, prio_of(irq_priority_regs_ff, i)} >= nxt_level))
         begin
            nxt_found = 1'b1;
            nxt_vector = FIRST_VECTOR + 8'(i);
            nxt_level = {1'b0, prio_of(irq_priority_regs_ff, i)};
         end
      end
      if (user_blocked || !global_ctrl_two_ff[GC2_GLOBAL_IRQ_ENABLE])
         nxt_found = 1'b0;
   end

   // pending vector register; holds its last value when nothing is pending
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_request_ff <= 1'b0;
         vector_number_ff <= 8'h00;
         pending_level_ff <= 4'h0;
      end
      else
      begin
         irq_request_ff <= nxt_found;
         if (nxt_found)
         begin
            vector_number_ff <= nxt_vector;
            pending_level_ff <= nxt_level;
         end
      end
   end

   // event sources: a freshly pending vector and any arriving trap
   always_comb
   begin
      evt_set = '0;
      evt_set[EVT_NEW_VECTOR] = nxt_found & ~irq_request_ff;
      evt_set[EVT_TRAP_FLAG] = |{trap_set3, trap_set4};
   end

   // event status: set wins over a write-one clear
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         evt_status_ff <= '0;
      else if (wr_en && paddr == ADDR_EVT_STATUS)
         evt_status_ff <= (evt_status_ff & ~wdata[NUM_EVT-1:0]) | evt_set;
      else
         evt_status_ff <= evt_status_ff | evt_set;
   end

   // event mask, plain software storage
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         evt_mask_ff <= '0;
      else if (wr_en && paddr == ADDR_EVT_MASK)
         evt_mask_ff <= wdata[NUM_EVT-1:0];
   end

   // level interrupt; registered so the pin never glitches, one cycle behind status
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         irq_out_ff <= 1'b0;
      else
         irq_out_ff <= |(evt_status_ff & evt_mask_ff);
   end

   // every output comes straight from its flip-flop
   assign pready = pready_ff;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;
   assign irq_request = irq_request_ff;
   assign vector_number = vector_number_ff;
   assign pending_level = pending_level_ff;
   assign variable_latency = variable_latency_ff;
   assign alternate_vector_table_enable = global_ctrl_two_ff[GC2_ALT_VECTOR_ENABLE];
   assign irq_out = irq_out_ff;

endmodule // priority_interrupt_controller
`default_nettype wire

/* File: src/prio_irq_pkg.sv */
package prio_irq_pkg;
   // source counts and vector numbering
   localparam int NUM_SRC = 16;
   localparam int NUM_EXT = 4;
   localparam int NUM_PERIPH = NUM_SRC - NUM_EXT;
   localparam int SRC_PER_PRIO_REG = 4;
   localparam int NUM_PRIO_REGS = NUM_SRC / SRC_PER_PRIO_REG;
   localparam int PRIO_FIELD_STRIDE = 4;
   localparam logic [7:0] FIRST_VECTOR = 8'h08;

   // apb byte addresses
   localparam logic [7:0] ADDR_GCTRL_ONE = 8'h00;
   localparam logic [7:0] ADDR_GCTRL_TWO = 8'h04;
   localparam logic [7:0] ADDR_GCTRL_THREE = 8'h08;
   localparam logic [7:0] ADDR_GCTRL_FOUR = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_FLAG = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
   localparam logic [7:0] ADDR_IRQ_PRIO0 = 8'h18;
   localparam logic [7:0] ADDR_PENDING_VEC = 8'h28;
   localparam logic [7:0] ADDR_CPU_STATUS = 8'h2C;
   localparam logic [7:0] ADDR_CORE_CTRL = 8'h30;
   localparam logic [7:0] ADDR_EVT_STATUS = 8'h34;
   localparam logic [7:0] ADDR_EVT_MASK = 8'h38;

   // global_ctrl_one fields
   localparam int GC1_NESTING_DISABLE = 15;
   localparam logic [15:0] GC1_WRITE_MASK = 16'hFFFE;
   // global_ctrl_two fields
   localparam int GC2_GLOBAL_IRQ_ENABLE = 15;
   localparam int GC2_ALT_VECTOR_ENABLE = 8;
   localparam logic [15:0] GC2_WRITE_MASK = 16'h810F;
   localparam logic [15:0] GC2_RESET = 16'h8000;
   // trap status flags
   localparam int GC3_AUX_PLL_FLAG = 8;
   localparam int GC3_LOOP_STACK_FLAG = 4;
   localparam int GC4_SOFT_HARD_TRAP = 0;
   // cpu_status_word and core_control_word fields
   localparam int SR_LEVEL_LSB = 5;
   localparam int CC_VARIABLE_LATENCY = 15;
   localparam int CC_LEVEL_MSB = 3;
   // event status bits
   localparam int EVT_NEW_VECTOR = 0;
   localparam int EVT_TRAP_FLAG = 1;
   localparam int NUM_EVT = 2;
   // level that blocks every user source
   localparam logic [2:0] LEVEL_BLOCK_ALL = 3'h7;
endpackage

/* File: tb/prio_irq_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module prio_irq_asserts
   import prio_irq_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        trap_level_msb,
   input wire logic        irq_request,
   input wire logic [7:0]  vector_number,
   input wire logic [3:0]  pending_level,
   input wire logic        variable_latency,
   input wire logic        alternate_vector_table_enable
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access");
   access_no_wait_a: assert property (psel && penable |-> pready)
      else $error("access not answered at once");
   // top bit passes a register before it gates the request
   msb_blocks_a: assert property ($past(trap_level_msb, 2) && $past(trap_level_msb, 3)
      |-> !irq_request)
      else $error("request while level top bit set");
   level_range_a: assert property (irq_request |-> pending_level inside {[1:7]})
      else $error("pending level out of range");
   vector_range_a: assert property (irq_request |-> vector_number inside {[8:23]})
      else $error("vector out of range");
   vector_hold_a: assert property (!irq_request ##1 !irq_request
      |-> $stable(vector_number) && $stable(pending_level))
      else $error("latched vector moved while idle");
   latency_write_a: assert property ($changed(variable_latency)
      |-> $past(psel && penable && pready && pwrite && paddr == ADDR_CORE_CTRL))
      else $error("latency bit changed without write");
   alt_write_a: assert property ($changed(alternate_vector_table_enable)
      |-> $past(psel && penable && pready && pwrite && paddr == ADDR_GCTRL_TWO))
      else $error("alternate table bit changed without write");
endmodule // prio_irq_asserts
`default_nettype wire

/* File: tb/irq_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_source_model
   import prio_irq_pkg::*;
(
   input  wire logic             clk,
   output logic [NUM_EXT-1:0]    external_request,
   output logic [NUM_PERIPH-1:0] periph_event,
   output logic                  aux_pll_trap,
   output logic                  loop_stack_trap,
   output logic                  soft_hard_trap,
   output logic                  trap_level_msb
);
   // all sources idle low so the first pulse is a clean rising edge
   initial
   begin
      external_request = '0;
      periph_event = '0;
      {aux_pll_trap, loop_stack_trap, soft_hard_trap} = 3'h0;
      trap_level_msb = 1'b0;
   end

   // one-cycle event; lines fall again so a later pulse is a new edge
   task automatic pulse(input logic [NUM_EXT-1:0] e, input logic [NUM_PERIPH-1:0] p,
                        input logic [2:0] t);
      @(posedge clk);
      external_request <= e;
      periph_event <= p;
      {aux_pll_trap, loop_stack_trap, soft_hard_trap} <= t;
      @(posedge clk);
      external_request <= '0;
      periph_event <= '0;
      {aux_pll_trap, loop_stack_trap, soft_hard_trap} <= 3'h0;
   endtask

   // core level above 7 while a trap runs; software cannot touch it
   task automatic set_msb(input logic v);
      @(posedge clk);
      trap_level_msb <= v;
   endtask
endmodule // irq_source_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import prio_irq_pkg::*;
();
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
   logic        aux, lst, sht, msb, irq_request, var_lat, alt_en, irq_out;
   logic [7:0]  paddr, vector_number;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0]  ext, pending_level;
   logic [11:0] pev;
   int          error_cnt = 0;
   int          comparisons = 0;

   priority_interrupt_controller u_dut (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .external_request(ext), .periph_event(pev),
      .aux_pll_trap(aux), .loop_stack_trap(lst), .soft_hard_trap(sht),
      .trap_level_msb(msb), .irq_request(irq_request), .vector_number(vector_number),
      .pending_level(pending_level), .variable_latency(var_lat),
      .alternate_vector_table_enable(alt_en), .irq_out(irq_out));
   irq_source_model u_src (.clk(clk), .external_request(ext), .periph_event(pev),
      .aux_pll_trap(aux), .loop_stack_trap(lst), .soft_hard_trap(sht),
      .trap_level_msb(msb));

   // free-running 100 ns clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic close_out;
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; the release edge passes before the next setup
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      logic got;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         n++;
      end
      got = pready;
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (got !== 1'b1)
      begin
         error_cnt++;
         close_out;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(rdata, exp);
   endtask

   // request, vector and level as seen by the core
   task automatic see(input logic r, input logic [7:0] v, input logic [3:0] l);
      repeat (3) @(posedge clk);
      chk({31'h0, irq_request}, {31'h0, r});
      if (r === 1'b1)
         chk({20'h0, pending_level, vector_number}, {20'h0, l, v});
   endtask

   initial
   begin
      resetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(ADDR_GCTRL_TWO, 32'h8000);
      rd(ADDR_CORE_CTRL, 32'h0);
      apb(8'h3C, 1'b0, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(ADDR_IRQ_PRIO0, 32'hFFFF);
      rd(ADDR_IRQ_PRIO0, 32'h7777);
      wr(8'h1C, 32'h0332);
      u_src.pulse(4'h0, 12'h007, 3'h0);
      rd(ADDR_IRQ_FLAG, 32'h0070);
      see(1'b0, 8'h0, 4'h0);
      wr(ADDR_IRQ_ENABLE, 32'h0070);
      see(1'b1, 8'h0D, 4'h3);
      rd(ADDR_PENDING_VEC, 32'h030D);
      wr(ADDR_IRQ_FLAG, 32'h0050);
      rd(ADDR_IRQ_FLAG, 32'h0050);
      see(1'b1, 8'h0E, 4'h3);
      wr(ADDR_CPU_STATUS, 32'h0060);
      rd(ADDR_CPU_STATUS, 32'h0060);
      see(1'b0, 8'h0, 4'h0);
      wr(ADDR_IRQ_ENABLE, 32'h0071);
      wr(ADDR_CPU_STATUS, 32'h00E0);
      u_src.pulse(4'h1, 12'h000, 3'h0);
      see(1'b0, 8'h0, 4'h0);
      wr(ADDR_CPU_STATUS, 32'h0000);
      see(1'b1, 8'h08, 4'h7);
      wr(ADDR_GCTRL_ONE, 32'h8000);
      wr(ADDR_CPU_STATUS, 32'h00A0);
      rd(ADDR_CPU_STATUS, 32'h0000);
      wr(ADDR_GCTRL_ONE, 32'h0000);
      wr(ADDR_CORE_CTRL, 32'h8008);
      rd(ADDR_CORE_CTRL, 32'h8000);
      chk({31'h0, var_lat}, 32'h1);
      u_src.set_msb(1'b1);
      see(1'b0, 8'h0, 4'h0);
      rd(ADDR_CORE_CTRL, 32'h8008);
      u_src.set_msb(1'b0);
      wr(ADDR_GCTRL_TWO, 32'h0100);
      see(1'b0, 8'h0, 4'h0);
      chk({31'h0, alt_en}, 32'h1);
      wr(ADDR_GCTRL_TWO, 32'h8000);
      see(1'b1, 8'h08, 4'h7);
      u_src.pulse(4'h0, 12'h000, 3'h7);
      rd(ADDR_GCTRL_THREE, 32'h0110);
      rd(ADDR_GCTRL_FOUR, 32'h0001);
      wr(ADDR_GCTRL_THREE, 32'h0110);
      rd(ADDR_GCTRL_THREE, 32'h0000);
      chk({31'h0, irq_out}, 32'h0);
      wr(ADDR_EVT_MASK, 32'h0002);
      see(1'b1, 8'h08, 4'h7);
      chk({31'h0, irq_out}, 32'h1);
      wr(ADDR_EVT_STATUS, 32'h0003);
      see(1'b1, 8'h08, 4'h7);
      chk({31'h0, irq_out}, 32'h0);
      // falling-edge select on pin 1: the rise must not set, the fall must
      wr(ADDR_GCTRL_TWO, 32'h8002);
      u_src.pulse(4'h2, 12'h000, 3'h0);
      rd(ADDR_IRQ_FLAG, 32'h0051);
      rd(ADDR_IRQ_FLAG, 32'h0053);
      close_out;
   end
endmodule // testbench

bind priority_interrupt_controller prio_irq_asserts u_chk (.clk(clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .trap_level_msb(trap_level_msb), .irq_request(irq_request),
   .vector_number(vector_number), .pending_level(pending_level),
   .variable_latency(variable_latency),
   .alternate_vector_table_enable(alternate_vector_table_enable));
`default_nettype wire
